// ===== design/acs_pkg.sv
// Shared constants and types for the side B second converter trim and step block.
package acs_pkg;

	// Register addresses on the plain register port.
	localparam logic [7:0] ACS_OFFSET_TRIM_ADDR = 8'hce;
	localparam logic [7:0] ACS_GAIN_TRIM_ADDR = 8'hcf;
	localparam logic [7:0] ACS_STEP_ZERO_ADDR = 8'hd0;
	localparam logic [7:0] ACS_STEP_ONE_ADDR = 8'hd1;
	localparam logic [7:0] ACS_SEQ_CTRL_ADDR = 8'he0;
	localparam logic [7:0] ACS_SEQ_STATUS_ADDR = 8'he1;
	localparam logic [7:0] ACS_RESULT_ADDR = 8'he2;

	// Reset values.
	localparam logic [15:0] ACS_OFFSET_TRIM_RESET = 16'h0000;
	localparam logic [15:0] ACS_GAIN_TRIM_RESET = 16'h0000;
	localparam logic [15:0] ACS_STEP_ZERO_RESET = 16'h0000;
	localparam logic [15:0] ACS_STEP_ONE_RESET = 16'h0001;
	localparam logic [15:0] ACS_ZERO_WORD = 16'h0000;

	// Step descriptor fields.
	localparam int ACS_STEP_EN_BIT = 15;
	localparam int ACS_STEP_GAIN_MSB = 14;
	localparam int ACS_STEP_GAIN_LSB = 13;
	localparam int ACS_STEP_NEG_BIT = 4;
	localparam int ACS_STEP_POS_MSB = 3;
	localparam int ACS_STEP_POS_LSB = 0;
	localparam logic [15:0] ACS_STEP_WRITE_MASK = 16'he01f;

	// Gain field codes.
	localparam logic [1:0] ACS_GAIN_CODE_ONE = 2'h0;
	localparam logic [1:0] ACS_GAIN_CODE_TWO = 2'h1;

	// Positive input codes.
	localparam logic [3:0] ACS_POS_TEMP = 4'h8;
	localparam logic [3:0] ACS_POS_SHORT = 4'h9;
	localparam logic [3:0] ACS_POS_TEST_DAC = 4'ha;
	localparam logic [3:0] ACS_POS_AUTO_FIRST = 4'h8;

	// Control and status fields.
	localparam int ACS_CTRL_START_BIT = 0;
	localparam int ACS_CTRL_CONT_BIT = 1;
	localparam int ACS_STAT_BUSY_BIT = 0;
	localparam int ACS_STAT_STEP_BIT = 1;
	localparam int ACS_STAT_WAIT_BIT = 2;

	// Sequencer size and trim arithmetic.
	localparam int ACS_STEPS = 2;
	localparam logic [0:0] ACS_LAST_STEP = 1'h1;
	localparam logic [0:0] ACS_FIRST_STEP = 1'h0;
	localparam logic signed [17:0] ACS_UNITY = 18'sh10000;
	localparam logic signed [19:0] ACS_SAT_MAX = 20'sh07fff;
	localparam logic signed [19:0] ACS_SAT_MIN = -20'sh08000;
	localparam logic [15:0] ACS_SAT_MAX_WORD = 16'h7fff;
	localparam logic [15:0] ACS_SAT_MIN_WORD = 16'h8000;

	typedef enum logic [1:0] {ACS_GAIN_ONE, ACS_GAIN_TWO, ACS_GAIN_FOUR} acs_gain_type;
	typedef enum logic [1:0] {ACS_NEG_GROUND, ACS_NEG_EXT_SEVEN, ACS_NEG_AUTO} acs_neg_type;
	typedef enum logic [2:0] {ACS_SRC_EXTERNAL, ACS_SRC_TEMP, ACS_SRC_SHORT, ACS_SRC_TEST_DAC,
		ACS_SRC_SUPPLY} acs_source_type;
	typedef enum logic [1:0] {ACS_IDLE, ACS_SEEK, ACS_WAIT} acs_seq_state_type;

endpackage

// ===== design/acs_step_decode.sv
// Decodes one sequence step descriptor into converter settings.
`timescale 1ns/100ps
module acs_step_decode
	import acs_pkg::*;
(
	// Stored descriptor.
	input wire logic [15:0] cfg,
	// Decoded settings.
	output logic enable,
	output acs_gain_type gain,
	output logic offset_double,
	output logic [3:0] pos_sel,
	output acs_neg_type neg_sel,
	output acs_source_type source
);

	logic [1:0] gain_code;

	always_comb begin
		gain_code = cfg[ACS_STEP_GAIN_MSB:ACS_STEP_GAIN_LSB];
		enable = cfg[ACS_STEP_EN_BIT];
		pos_sel = cfg[ACS_STEP_POS_MSB:ACS_STEP_POS_LSB];
		case (gain_code)
			ACS_GAIN_CODE_ONE: gain = ACS_GAIN_ONE;
			ACS_GAIN_CODE_TWO: gain = ACS_GAIN_TWO;
			default: gain = ACS_GAIN_FOUR;
		endcase
		// At gain four one offset code spans two raw converter codes.
		offset_double = (gain == ACS_GAIN_FOUR);
		if (pos_sel >= ACS_POS_AUTO_FIRST) begin
			neg_sel = ACS_NEG_AUTO;
			case (pos_sel)
				ACS_POS_TEMP: source = ACS_SRC_TEMP;
				ACS_POS_SHORT: source = ACS_SRC_SHORT;
				ACS_POS_TEST_DAC: source = ACS_SRC_TEST_DAC;
				default: source = ACS_SRC_SUPPLY;
			endcase
		end else begin
			source = ACS_SRC_EXTERNAL;
			neg_sel = cfg[ACS_STEP_NEG_BIT] ? ACS_NEG_EXT_SEVEN : ACS_NEG_GROUND;
		end
	end

endmodule

// ===== design/acs_trim_seq.sv
// Trim registers, step descriptors and step sequencer of the side B second converter.
// How it works
// - Offset trim is a 16-bit two's-complement read/write register.
// - Offset code equals one raw code at gain one or two, two at gain four.
// - Result is multiplied by one plus gain trim over 65536.
// - A step takes part in the sequence only when its enable bit is one.
// - Gain field 00 gives one, 01 gives two, 10 and 11 give four.
// - Negative select zero picks analog ground, one picks external input seven.
// - Positive codes 0-7 external, 8 temperature, 9 short, 10 test DAC, above supplies.
// - Positive codes 8 and above select negative input automatically, ignoring negative bit.
// - Step bits 12:5 read zero and ignore writes.
// - Offset trim resets to zero.
// - Gain trim resets to zero, giving unity.
// - Step one resets to 0001h, step zero to zero.
// - Setting the start bit aborts any running sequence and restarts it.
`timescale 1ns/100ps
module acs_trim_seq
	import acs_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Converter control.
	output logic conv_start,
	output logic conv_abort,
	output acs_gain_type conv_gain,
	output logic [3:0] conv_pos_sel,
	output acs_neg_type conv_neg_sel,
	output acs_source_type conv_source,
	input wire logic conv_done,
	input wire logic [15:0] conv_raw,
	// Corrected results.
	output logic [15:0] result_data,
	output logic result_step,
	output logic result_valid,
	output logic seq_busy
);

	// Applies offset and gain trim to one raw code and saturates to 16 bits.
	function automatic logic [15:0] trim_code(input logic [15:0] raw, input logic [15:0] off,
		input logic off_double, input logic [15:0] gtrim);
		logic signed [17:0] off_e;
		logic signed [17:0] diff;
		logic signed [17:0] fac;
		logic signed [35:0] prod;
		logic signed [19:0] scaled;
		logic [15:0] res;
		off_e = off_double ? {off[15], off, 1'b0} : {{2{off[15]}}, off};
		diff = $signed({{2{raw[15]}}, raw}) - off_e;
		fac = ACS_UNITY + $signed({{2{gtrim[15]}}, gtrim});
		prod = diff * fac;
		scaled = prod[35:16];
		if (scaled > ACS_SAT_MAX) begin
			res = ACS_SAT_MAX_WORD;
		end else if (scaled < ACS_SAT_MIN) begin
			res = ACS_SAT_MIN_WORD;
		end else begin
			res = scaled[15:0];
		end
		return res;
	endfunction

	// Register state.
	logic [15:0] offset_trim_q;
	logic [15:0] offset_trim_d;
	logic [15:0] gain_trim_q;
	logic [15:0] gain_trim_d;
	logic [15:0] step_cfg_q [ACS_STEPS];
	logic [15:0] step_cfg_d [ACS_STEPS];
	logic cont_q;
	logic cont_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic start_req;

	// Sequencer state.
	acs_seq_state_type state_q;
	acs_seq_state_type state_d;
	logic [0:0] idx_q;
	logic [0:0] idx_d;
	logic conv_start_q;
	logic conv_start_d;
	logic conv_abort_q;
	logic conv_abort_d;
	acs_gain_type gain_q;
	acs_gain_type gain_d;
	logic off_double_q;
	logic off_double_d;
	logic [3:0] pos_q;
	logic [3:0] pos_d;
	acs_neg_type neg_q;
	acs_neg_type neg_d;
	acs_source_type src_q;
	acs_source_type src_d;
	logic [15:0] result_q;
	logic [15:0] result_d;
	logic result_step_q;
	logic result_step_d;
	logic result_valid_q;
	logic result_valid_d;

	// Decoded step descriptors.
	logic step_en [ACS_STEPS];
	acs_gain_type step_gain [ACS_STEPS];
	logic step_off_double [ACS_STEPS];
	logic [3:0] step_pos [ACS_STEPS];
	acs_neg_type step_neg [ACS_STEPS];
	acs_source_type step_src [ACS_STEPS];

	genvar gi;
	generate
		for (gi = 0; gi < ACS_STEPS; gi++) begin : g_step
			acs_step_decode u_decode (
				.cfg(step_cfg_q[gi]),
				.enable(step_en[gi]),
				.gain(step_gain[gi]),
				.offset_double(step_off_double[gi]),
				.pos_sel(step_pos[gi]),
				.neg_sel(step_neg[gi]),
				.source(step_src[gi])
			);
		end
	endgenerate

	// Register writes and reads.
	always_comb begin
		offset_trim_d = offset_trim_q;
		gain_trim_d = gain_trim_q;
		step_cfg_d[0] = step_cfg_q[0];
		step_cfg_d[1] = step_cfg_q[1];
		cont_d = cont_q;
		start_req = 1'b0;
		rdata_d = ACS_ZERO_WORD;
		if (reg_wr) begin
			case (reg_addr)
				ACS_OFFSET_TRIM_ADDR: offset_trim_d = reg_wdata;
				ACS_GAIN_TRIM_ADDR: gain_trim_d = reg_wdata;
				ACS_STEP_ZERO_ADDR: step_cfg_d[0] = reg_wdata & ACS_STEP_WRITE_MASK;
				ACS_STEP_ONE_ADDR: step_cfg_d[1] = reg_wdata & ACS_STEP_WRITE_MASK;
				ACS_SEQ_CTRL_ADDR: begin
					cont_d = reg_wdata[ACS_CTRL_CONT_BIT];
					start_req = reg_wdata[ACS_CTRL_START_BIT];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ACS_OFFSET_TRIM_ADDR: rdata_d = offset_trim_q;
				ACS_GAIN_TRIM_ADDR: rdata_d = gain_trim_q;
				ACS_STEP_ZERO_ADDR: rdata_d = step_cfg_q[0] & ACS_STEP_WRITE_MASK;
				ACS_STEP_ONE_ADDR: rdata_d = step_cfg_q[1] & ACS_STEP_WRITE_MASK;
				ACS_SEQ_CTRL_ADDR: rdata_d[ACS_CTRL_CONT_BIT] = cont_q;
				ACS_SEQ_STATUS_ADDR: begin
					rdata_d[ACS_STAT_BUSY_BIT] = (state_q != ACS_IDLE);
					rdata_d[ACS_STAT_STEP_BIT] = idx_q[0];
					rdata_d[ACS_STAT_WAIT_BIT] = (state_q == ACS_WAIT);
				end
				ACS_RESULT_ADDR: rdata_d = result_q;
				default: rdata_d = ACS_ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			offset_trim_q <= ACS_OFFSET_TRIM_RESET;
			gain_trim_q <= ACS_GAIN_TRIM_RESET;
			step_cfg_q[0] <= ACS_STEP_ZERO_RESET;
			step_cfg_q[1] <= ACS_STEP_ONE_RESET;
			cont_q <= 1'b0;
			rdata_q <= ACS_ZERO_WORD;
		end else begin
			offset_trim_q <= offset_trim_d;
			gain_trim_q <= gain_trim_d;
			step_cfg_q[0] <= step_cfg_d[0];
			step_cfg_q[1] <= step_cfg_d[1];
			cont_q <= cont_d;
			rdata_q <= rdata_d;
		end
	end

	// Step sequencer.
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		conv_start_d = 1'b0;
		conv_abort_d = 1'b0;
		gain_d = gain_q;
		off_double_d = off_double_q;
		pos_d = pos_q;
		neg_d = neg_q;
		src_d = src_q;
		result_d = result_q;
		result_step_d = result_step_q;
		result_valid_d = 1'b0;
		if (start_req) begin
			// A conversion in flight is dropped and its completion never reported.
			state_d = ACS_SEEK;
			idx_d = ACS_FIRST_STEP;
			conv_abort_d = (state_q == ACS_WAIT);
		end else begin
			case (state_q)
				ACS_IDLE: begin
				end
				ACS_SEEK: begin
					if (step_en[idx_q]) begin
						conv_start_d = 1'b1;
						gain_d = step_gain[idx_q];
						off_double_d = step_off_double[idx_q];
						pos_d = step_pos[idx_q];
						neg_d = step_neg[idx_q];
						src_d = step_src[idx_q];
						state_d = ACS_WAIT;
					end else if (idx_q == ACS_LAST_STEP) begin
						idx_d = ACS_FIRST_STEP;
						state_d = cont_q ? ACS_SEEK : ACS_IDLE;
					end else begin
						idx_d = idx_q + 1'b1;
					end
				end
				ACS_WAIT: begin
					if (conv_done) begin
						result_d = trim_code(conv_raw, offset_trim_q, off_double_q, gain_trim_q);
						result_step_d = idx_q[0];
						result_valid_d = 1'b1;
						if (idx_q == ACS_LAST_STEP) begin
							idx_d = ACS_FIRST_STEP;
							state_d = cont_q ? ACS_SEEK : ACS_IDLE;
						end else begin
							idx_d = idx_q + 1'b1;
							state_d = ACS_SEEK;
						end
					end
				end
				default: begin
					state_d = ACS_IDLE;
					idx_d = ACS_FIRST_STEP;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ACS_IDLE;
			idx_q <= ACS_FIRST_STEP;
			conv_start_q <= 1'b0;
			conv_abort_q <= 1'b0;
			gain_q <= ACS_GAIN_ONE;
			off_double_q <= 1'b0;
			pos_q <= 4'h0;
			neg_q <= ACS_NEG_GROUND;
			src_q <= ACS_SRC_EXTERNAL;
			result_q <= ACS_ZERO_WORD;
			result_step_q <= 1'b0;
			result_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			conv_start_q <= conv_start_d;
			conv_abort_q <= conv_abort_d;
			gain_q <= gain_d;
			off_double_q <= off_double_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
			src_q <= src_d;
			result_q <= result_d;
			result_step_q <= result_step_d;
			result_valid_q <= result_valid_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign conv_start = conv_start_q;
	assign conv_abort = conv_abort_q;
	assign conv_gain = gain_q;
	assign conv_pos_sel = pos_q;
	assign conv_neg_sel = neg_q;
	assign conv_source = src_q;
	assign result_data = result_q;
	assign result_step = result_step_q;
	assign result_valid = result_valid_q;
	assign seq_busy = (state_q != ACS_IDLE);

endmodule

// ===== testbench/acs_trim_seq_sva.sv
// Assertion checker for the trim registers and step sequencer.
`timescale 1ns/100ps
module acs_trim_seq_sva
	import acs_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Converter control.
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire acs_gain_type conv_gain,
	input wire logic [3:0] conv_pos_sel,
	input wire acs_neg_type conv_neg_sel,
	input wire acs_source_type conv_source,
	input wire logic conv_done,
	input wire logic [15:0] conv_raw,
	// Results.
	input wire logic [15:0] result_data,
	input wire logic result_step,
	input wire logic result_valid,
	input wire logic seq_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_start_wr;
		reg_wr && reg_addr == ACS_SEQ_CTRL_ADDR && reg_wdata[ACS_CTRL_START_BIT];
	endsequence
	sequence s_step_rd;
		reg_rd && (reg_addr == ACS_STEP_ZERO_ADDR || reg_addr == ACS_STEP_ONE_ADDR);
	endsequence
	property p_rd_idle;
		!reg_rd |=> reg_rdata == ACS_ZERO_WORD;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
	property p_rsvd_zero;
		s_step_rd |=> reg_rdata[12:5] == 8'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("step reserved bits not zero");
	property p_start_busy;
		s_start_wr |=> seq_busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not make sequencer busy");
	property p_start_once;
		conv_start |=> !conv_start;
	endproperty
	a_start_once: assert property (p_start_once) else $error("conversion start longer than one cycle");
	property p_auto_neg;
		conv_start && conv_pos_sel >= ACS_POS_AUTO_FIRST |-> conv_neg_sel == ACS_NEG_AUTO;
	endproperty
	a_auto_neg: assert property (p_auto_neg) else $error("internal source without automatic negative");
	property p_ext_src;
		conv_start && conv_pos_sel < ACS_POS_AUTO_FIRST |-> conv_source == ACS_SRC_EXTERNAL && conv_neg_sel != ACS_NEG_AUTO;
	endproperty
	a_ext_src: assert property (p_ext_src) else $error("external code decoded wrongly");
	property p_short_src;
		conv_start && conv_pos_sel == ACS_POS_SHORT |-> conv_source == ACS_SRC_SHORT;
	endproperty
	a_short_src: assert property (p_short_src) else $error("short code decoded wrongly");
	property p_hold;
		!conv_start && !$past(srst) |-> $stable(conv_gain) && $stable(conv_pos_sel) && $stable(conv_source);
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed without a launch");
	property p_abort_cause;
		conv_abort |-> $past(reg_wr) && $past(reg_addr) == ACS_SEQ_CTRL_ADDR;
	endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("abort without a start write");
	property p_result_cause;
		result_valid |-> $past(conv_done);
	endproperty
	a_result_cause: assert property (p_result_cause) else $error("result without conversion done");
endmodule

bind acs_trim_seq acs_trim_seq_sva u_sva (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_abort(conv_abort),
	.conv_gain(conv_gain), .conv_pos_sel(conv_pos_sel), .conv_neg_sel(conv_neg_sel), .conv_source(conv_source),
	.conv_done(conv_done), .conv_raw(conv_raw), .result_data(result_data), .result_step(result_step),
	.result_valid(result_valid), .seq_busy(seq_busy));

// ===== testbench/tb.sv
// Self-checking testbench for the trim registers and step sequencer.
`timescale 1ns/100ps
module tb import acs_pkg::*;;
	logic clk, srst, reg_wr, reg_rd, conv_done, conv_start, conv_abort, result_step, result_valid, seq_busy;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, conv_raw, reg_rdata, result_data;
	logic [3:0] conv_pos_sel;
	acs_gain_type conv_gain;
	acs_neg_type conv_neg_sel;
	acs_source_type conv_source;
	int err_count, comparisons, cycles;
	acs_trim_seq u_acs_trim_seq (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_abort(conv_abort),
		.conv_gain(conv_gain), .conv_pos_sel(conv_pos_sel), .conv_neg_sel(conv_neg_sel), .conv_source(conv_source),
		.conv_done(conv_done), .conv_raw(conv_raw), .result_data(result_data), .result_step(result_step),
		.result_valid(result_valid), .seq_busy(seq_busy));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test;
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hung handshake ends the run here.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	function automatic logic sig(input int k);
		return (k == 0) ? conv_start : (k == 1) ? result_valid : conv_abort;
	endfunction
	// Waits a bounded number of cycles for a start, result or abort pulse.
	task automatic wait_sig(input int k);
		int n;
		n = 0;
		while (sig(k) !== 1'b1 && n < 12) begin
			@(posedge clk);
			#1;
			n++;
		end
		check({15'h0000, sig(k)}, 16'h0001);
	endtask
	task automatic run(input logic [15:0] c0, input logic [15:0] c1);
		wr(8'hd0, c0);
		wr(8'hd1, c1);
		wr(8'he0, 16'h0001);
	endtask
	task automatic conv(input logic [15:0] g, p, n, s, raw, st, res);
		wait_sig(0);
		check(16'(conv_gain), g);
		check(16'(conv_pos_sel), p);
		check(16'(conv_neg_sel), n);
		check(16'(conv_source), s);
		@(posedge clk);
		conv_done <= 1'b1;
		conv_raw <= raw;
		@(posedge clk);
		conv_done <= 1'b0;
		#1;
		wait_sig(1);
		check(result_data, res);
		check({15'h0000, result_step}, st);
	endtask
	task automatic t_reset_values;
		rd(8'hce, 16'h0000);
		rd(8'hcf, 16'h0000);
		rd(8'hd0, 16'h0000);
		rd(8'hd1, 16'h0001);
		rd(8'he0, 16'h0000);
		rd(8'he1, 16'h0000);
		rd(8'he2, 16'h0000);
		check({15'h0000, seq_busy}, 16'h0000);
	endtask
	task automatic t_reg_access;
		wr(8'hce, 16'h8001);
		rd(8'hce, 16'h8001);
		wr(8'hcf, 16'h7fff);
		rd(8'hcf, 16'h7fff);
		wr(8'hd0, 16'hffff);
		rd(8'hd0, 16'he01f);
		wr(8'hd1, 16'hffff);
		rd(8'hd1, 16'he01f);
		wr(8'hc0, 16'h1234);
		rd(8'hc0, 16'h0000);
		wr(8'he0, 16'h0002);
		rd(8'he0, 16'h0002);
		wr(8'he0, 16'h0000);
	endtask
	task automatic t_trim_seq;
		// Offset of 16 codes and a gain factor of one half.
		wr(8'hce, 16'h0010);
		wr(8'hcf, 16'h8000);
		run(16'he013, 16'h601f);
		conv(ACS_GAIN_FOUR, 16'h3, ACS_NEG_EXT_SEVEN, ACS_SRC_EXTERNAL, 16'h1020, 16'h0, 16'h0800);
		rd(8'he2, 16'h0800);
		run(16'ha007, 16'hc018);
		conv(ACS_GAIN_TWO, 16'h7, ACS_NEG_GROUND, ACS_SRC_EXTERNAL, 16'h0210, 16'h0, 16'h0100);
		conv(ACS_GAIN_FOUR, 16'h8, ACS_NEG_AUTO, ACS_SRC_TEMP, 16'h0120, 16'h1, 16'h0080);
		run(16'h601f, 16'h8019);
		conv(ACS_GAIN_ONE, 16'h9, ACS_NEG_AUTO, ACS_SRC_SHORT, 16'hfff0, 16'h1, 16'hfff0);
	endtask
	task automatic t_abort;
		run(16'h800a, 16'h800f);
		wait_sig(0);
		rd(8'he1, 16'h0005);
		wr(8'he0, 16'h0001);
		wait_sig(2);
		conv(ACS_GAIN_ONE, 16'ha, ACS_NEG_AUTO, ACS_SRC_TEST_DAC, 16'h0010, 16'h0, 16'h0000);
		conv(ACS_GAIN_ONE, 16'hf, ACS_NEG_AUTO, ACS_SRC_SUPPLY, 16'h0010, 16'h1, 16'h0000);
	endtask
	task automatic t_continuous;
		wr(8'he0, 16'h0003);
		conv(ACS_GAIN_ONE, 16'ha, ACS_NEG_AUTO, ACS_SRC_TEST_DAC, 16'h0030, 16'h0, 16'h0010);
		conv(ACS_GAIN_ONE, 16'hf, ACS_NEG_AUTO, ACS_SRC_SUPPLY, 16'h0050, 16'h1, 16'h0020);
		conv(ACS_GAIN_ONE, 16'ha, ACS_NEG_AUTO, ACS_SRC_TEST_DAC, 16'h0070, 16'h0, 16'h0030);
	endtask
	// Reset lands while the looping sequence has a conversion in flight.
	task automatic t_mid_reset;
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
	endtask
	initial begin
		{srst, reg_wr, reg_rd, conv_done} = 4'h8;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		conv_raw = 16'h0000;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
		t_reg_access();
		t_trim_seq();
		t_abort();
		t_continuous();
		t_mid_reset();
		stop_test();
	end
endmodule
